// [vfd_video_frame_dma.sv]
// Behaviour
// R1: Stream-to-memory: write each received pixel to memory; code drops beats taken at frame start without snkSop
// R2: Memory-to-stream: fetch pixels, emit on stream output
// R3: Sink port live only in stream-to-memory build
// R4: Source port live only in memory-to-stream build
// R5: Consecutive or X-Y addressing, scaled by pixel bytes
// R6: Reset loads both start addresses from defaults
// R7: Offset 0 reads active frame start address
// R8: Offset 4 holds software's next frame address
// R9: Software writes pending, then writes offset 0
// R10: Write to offset 0 requests swap; data dropped
// R11: Swap happens after last pixel of frame
// R12: Status bit 0 shows swap still pending
// R13: Offset 8 reads width low, height high
// R14: Offset 12 reads status, writes control
// R15: Status 31-24 Y width, 23-16 X width
// R16: Status 11-8 and 7-6 report pixel format
// R17: Bit 2 run control; clear stops transfers
// R18: Status bit 1 is addressing style
// R19: Software writes zero to reserved bits
// R20: Frame size and pixel format fixed at build
// R21: X-Y address puts line above pixel index
// R22: Stream marks first and last pixel of frame
`timescale 1ns/1ns
`default_nettype none
module vfd_video_frame_dma #(
   parameter logic DIRECTION = vfd_pkg::DIR_STREAM_TO_MEM,
   parameter logic MODE = vfd_pkg::MODE_CONSECUTIVE,
   parameter logic [31:0] DEFAULT_START = 32'h0000_0000,
   parameter logic [31:0] DEFAULT_PENDING = 32'h0000_0000,
   parameter int WIDTH = 640,
   parameter int HEIGHT = 480,
   parameter int SYM_BITS = 8,
   parameter int SYMS = 3,
   localparam int PIX_W = SYM_BITS * SYMS,
   localparam int BYTES = 2 ** $clog2((PIX_W + 7) / 8),
   localparam int MW = BYTES * 8
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire vfd_pkg::vfd_reg_req_t regReq,
   output logic [31:0] regRdata,
   output logic [31:0] memAddr,
   output logic memRead,
   output logic memWrite,
   output logic [MW-1:0] memWdata,
   input wire logic [MW-1:0] memRdata,
   input wire logic memRdValid,
   input wire logic memWait,
   input wire logic [PIX_W-1:0] snkData,
   input wire logic snkSop,
   input wire logic snkEop,
   input wire logic snkValid,
   output logic snkReady,
   output logic [PIX_W-1:0] srcData,
   output logic srcSop,
   output logic srcEop,
   output logic srcValid,
   input wire logic srcReady
);

   // R20: geometry and format are fixed here
   localparam int XB = $clog2(WIDTH);
   localparam int YB = $clog2(HEIGHT);
   localparam int SHIFT = $clog2(BYTES);

   typedef enum {
      S_ISSUE,
      S_TAKE,
      S_WRITE,
      S_READ,
      S_RWAIT,
      S_EMIT
   } vfd_state_t;

   vfd_state_t state_q;
   logic [31:0] active_q;
   logic [31:0] pending_q;
   logic swapReq_q;
   logic run_q;
   logic [31:0] regRdata_q;
   logic [31:0] memAddr_q;
   logic memRead_q;
   logic memWrite_q;
   logic [MW-1:0] memWdata_q;
   logic snkReady_q;
   logic [PIX_W-1:0] srcData_q;
   logic srcSop_q;
   logic srcEop_q;
   logic srcValid_q;

   logic [31:0] pixAddr;
   logic pixFirst;
   logic pixLast;
   logic step;
   logic restart;
   logic frameDone;
   logic wrActive;
   logic wrPending;
   logic wrControl;
   logic [31:0] statusWord;
   logic [31:0] dimWord;

   assign regRdata = regRdata_q;
   assign memAddr = memAddr_q;
   assign memRead = memRead_q;
   assign memWrite = memWrite_q;
   assign memWdata = memWdata_q;
   assign snkReady = snkReady_q;
   assign srcData = srcData_q;
   assign srcSop = srcSop_q;
   assign srcEop = srcEop_q;
   assign srcValid = srcValid_q;

   // A pixel counts as moved only when its memory write or stream beat completes
   assign step = ((state_q == S_WRITE) && !memWait) || ((state_q == S_EMIT) && srcReady);
   // R17
   assign restart = (state_q == S_ISSUE) && !run_q;
   assign frameDone = step && pixLast; // R11

   assign wrActive = regReq.wr && (regReq.addr == vfd_pkg::OFS_FRAME_START); // R10
   assign wrPending = regReq.wr && (regReq.addr == vfd_pkg::OFS_PENDING_START);
   assign wrControl = regReq.wr && (regReq.addr == vfd_pkg::OFS_STATUS_CONTROL); // R14

   vfd_addr_gen #(
      .WIDTH(WIDTH),
      .HEIGHT(HEIGHT),
      .XB(XB),
      .YB(YB),
      .SHIFT(SHIFT),
      .MODE(MODE)
   ) u_addr (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .restart(restart),
      .step(step),
      .base(active_q),
      .addr(pixAddr),
      .first(pixFirst),
      .last(pixLast)
   );

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[vfd_pkg::ST_YW_LSB +: 8] = 8'(YB); // R15
      statusWord[vfd_pkg::ST_XW_LSB +: 8] = 8'(XB); // R15
      statusWord[vfd_pkg::ST_SYM_WIDTH_LSB +: 4] = 4'(SYM_BITS - 1); // R16
      statusWord[vfd_pkg::ST_BEAT_SYM_LSB +: 2] = 2'(SYMS - 1); // R16
      statusWord[vfd_pkg::ST_RUN_BIT] = run_q; // R17
      statusWord[vfd_pkg::ST_MODE_BIT] = MODE; // R18
      statusWord[vfd_pkg::ST_SWAP_BIT] = swapReq_q; // R12
      dimWord = {16'(HEIGHT), 16'(WIDTH)}; // R13
   end

   // Register read port, one cycle latency; unmapped bits read as zero
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         regRdata_q <= vfd_pkg::RDATA_RESET;
      else if (regReq.rd)
      begin
         case (regReq.addr)
            vfd_pkg::OFS_FRAME_START: regRdata_q <= active_q; // R7
            vfd_pkg::OFS_PENDING_START: regRdata_q <= pending_q; // R8
            vfd_pkg::OFS_DIMENSIONS: regRdata_q <= dimWord; // R13
            vfd_pkg::OFS_STATUS_CONTROL: regRdata_q <= statusWord; // R14
            default: regRdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Start addresses and the deferred exchange
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active_q <= DEFAULT_START; // R6
         pending_q <= DEFAULT_PENDING; // R6
         swapReq_q <= 1'b0;
      end
      else
      begin
         if (frameDone && swapReq_q)
            active_q <= pending_q; // R11
         if (wrPending)
            pending_q <= regReq.wdata; // R8
         else if (frameDone && swapReq_q)
            pending_q <= active_q; // R11
         // A request arriving on the swap edge stays pending for the next frame
         if (wrActive)
            swapReq_q <= 1'b1; // R10
         else if (frameDone)
            swapReq_q <= 1'b0; // R12
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         run_q <= vfd_pkg::RUN_RESET;
      else if (wrControl)
         run_q <= regReq.wdata[vfd_pkg::ST_RUN_BIT]; // R17
   end

   // Transfer engine; a bus cycle or source stream beat already begun is always finished
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= S_ISSUE;
         memAddr_q <= 32'h0000_0000;
         memRead_q <= 1'b0;
         memWrite_q <= 1'b0;
         memWdata_q <= '0;
         snkReady_q <= 1'b0;
         srcData_q <= '0;
         srcSop_q <= 1'b0;
         srcEop_q <= 1'b0;
         srcValid_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            S_ISSUE:
            begin
               if (run_q && DIRECTION == vfd_pkg::DIR_STREAM_TO_MEM)
               begin
                  snkReady_q <= 1'b1; // R3
                  state_q <= S_TAKE;
               end
               else if (run_q)
               begin
                  memAddr_q <= pixAddr; // R2
                  memRead_q <= 1'b1;
                  state_q <= S_READ;
               end
            end
            S_TAKE:
            begin
               if (!run_q)
               begin
                  snkReady_q <= 1'b0; // R17
                  state_q <= S_ISSUE;
               end
               else if (snkValid)
               begin
                  // Until a frame start is seen, beats are dropped to regain alignment
                  if (!pixFirst || snkSop) // R22
                  begin
                     snkReady_q <= 1'b0;
                     memAddr_q <= pixAddr; // R1
                     memWdata_q <= MW'(snkData);
                     memWrite_q <= 1'b1;
                     state_q <= S_WRITE;
                  end
               end
            end
            S_WRITE:
            begin
               if (!memWait)
               begin
                  memWrite_q <= 1'b0; // R1
                  state_q <= S_ISSUE;
               end
            end
            S_READ:
            begin
               if (!memWait)
               begin
                  memRead_q <= 1'b0;
                  state_q <= S_RWAIT;
               end
            end
            S_RWAIT:
            begin
               if (memRdValid)
               begin
                  srcData_q <= memRdata[PIX_W-1:0]; // R2
                  srcSop_q <= pixFirst; // R22
                  srcEop_q <= pixLast; // R22
                  srcValid_q <= 1'b1; // R4
                  state_q <= S_EMIT;
               end
            end
            S_EMIT:
            begin
               if (srcReady)
               begin
                  srcValid_q <= 1'b0;
                  srcSop_q <= 1'b0;
                  srcEop_q <= 1'b0;
                  state_q <= S_ISSUE;
               end
            end
            default:
            begin
               state_q <= S_ISSUE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// [vfd_pkg.sv]
package vfd_pkg;

   // Byte offsets of the control port
   localparam logic [3:0] OFS_FRAME_START = 4'h0;
   localparam logic [3:0] OFS_PENDING_START = 4'h4;
   localparam logic [3:0] OFS_DIMENSIONS = 4'h8;
   localparam logic [3:0] OFS_STATUS_CONTROL = 4'hc;

   // Status, control and dimension field positions
   localparam int ST_SWAP_BIT = 0;
   localparam int ST_MODE_BIT = 1;
   localparam int ST_RUN_BIT = 2;
   localparam int ST_BEAT_SYM_LSB = 6;
   localparam int ST_SYM_WIDTH_LSB = 8;
   localparam int ST_XW_LSB = 16;
   localparam int ST_YW_LSB = 24;
   localparam int DIM_Y_LSB = 16;

   // Values after reset
   localparam logic RUN_RESET = 1'b1;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // Direction and addressing encodings
   localparam logic DIR_STREAM_TO_MEM = 1'b1;
   localparam logic DIR_MEM_TO_STREAM = 1'b0;
   localparam logic MODE_XY = 1'b0;
   localparam logic MODE_CONSECUTIVE = 1'b1;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [31:0] wdata;
   } vfd_reg_req_t;

endpackage

// [vfd_addr_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module vfd_addr_gen #(
   parameter int WIDTH = 640,
   parameter int HEIGHT = 480,
   parameter int XB = 10,
   parameter int YB = 9,
   parameter int SHIFT = 2,
   parameter logic MODE = vfd_pkg::MODE_CONSECUTIVE
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic restart,
   input wire logic step,
   input wire logic [31:0] base,
   output logic [31:0] addr,
   output logic first,
   output logic last
);

   logic [XB-1:0] x_q;
   logic [YB-1:0] y_q;
   logic [31:0] lin_q;
   logic [31:0] offset;

   assign first = (x_q == '0) && (y_q == '0);
   assign last = (x_q == XB'(WIDTH - 1)) && (y_q == YB'(HEIGHT - 1));

   always_comb
   begin
      // Line index sits above pixel index in a power-of-two row pitch
      if (MODE == vfd_pkg::MODE_XY)
         offset = (32'(y_q) << XB) | 32'(x_q); // R21
      else
         offset = lin_q;
      addr = base + (offset << SHIFT); // R5
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         x_q <= '0;
         y_q <= '0;
         lin_q <= 32'h0000_0000;
      end
      else if (restart || (step && last))
      begin
         x_q <= '0;
         y_q <= '0;
         lin_q <= 32'h0000_0000;
      end
      else if (step)
      begin
         lin_q <= lin_q + 32'h0000_0001;
         if (x_q == XB'(WIDTH - 1))
         begin
            x_q <= '0;
            y_q <= y_q + YB'(1);
         end
         else
            x_q <= x_q + XB'(1);
      end
   end

endmodule
`default_nettype wire

// [vfd_dma_props.sv]
`timescale 1ns/1ns
`default_nettype none
module vfd_dma_props #(
   parameter int WIDTH = 3,
   parameter int HEIGHT = 2,
   parameter int SYM_BITS = 8,
   parameter int SYMS = 3,
   parameter logic MODE = 1'b0,
   parameter logic DIRECTION = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire vfd_pkg::vfd_reg_req_t regReq,
   input wire logic [31:0] regRdata,
   input wire logic [31:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic memWait,
   input wire logic snkValid,
   input wire logic snkReady,
   input wire logic srcValid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic run_q;
   logic [4:0] stopCnt_q;
   logic rdSt;
   assign rdSt = regReq.rd && regReq.addr == vfd_pkg::OFS_STATUS_CONTROL;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         run_q <= 1'b1;
      else if (regReq.wr && regReq.addr == vfd_pkg::OFS_STATUS_CONTROL)
         run_q <= regReq.wdata[2];
   end
   // Saturates so a long stop never wraps back into the busy window
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         stopCnt_q <= 5'h0;
      else if (run_q)
         stopCnt_q <= 5'h0;
      else if (stopCnt_q != 5'h1f)
         stopCnt_q <= stopCnt_q + 5'h1;
   end
   sequence beatTaken;
      snkValid && snkReady;
   endsequence
   sequence wordOut;
      memWrite && !snkReady;
   endsequence
   chk_beat_to_word: assert property (beatTaken |=> wordOut)
      else $error("taken beat gave no memory write");
   chk_write_hold: assert property (memWrite && memWait |=> memWrite && $stable(memAddr))
      else $error("write dropped or moved while stalled");
   chk_write_once: assert property (memWrite && !memWait |=> !memWrite)
      else $error("write repeated after acceptance");
   chk_source_idle: assert property (DIRECTION == vfd_pkg::DIR_STREAM_TO_MEM
      |-> !memRead && !srcValid)
      else $error("fetch or source traffic in sink build");
   chk_sink_idle: assert property (DIRECTION == vfd_pkg::DIR_MEM_TO_STREAM
      |-> !memWrite && !snkReady)
      else $error("write or sink traffic in source build");
   chk_dims_read: assert property (regReq.rd && regReq.addr == 4'h8
      |=> regRdata == {16'(HEIGHT), 16'(WIDTH)})
      else $error("dimensions read wrong");
   chk_status_fields: assert property (rdSt |=> regRdata[31:24] == $clog2(HEIGHT)
      && regRdata[23:16] == $clog2(WIDTH) && regRdata[11:8] == SYM_BITS - 1
      && regRdata[7:6] == SYMS - 1 && regRdata[1] == MODE)
      else $error("status constant fields wrong");
   chk_run_bit: assert property (rdSt |=> regRdata[2] == $past(run_q))
      else $error("run bit read wrong");
   chk_stop_quiet: assert property (stopCnt_q >= 5'h10 |-> !memWrite && !snkReady)
      else $error("transfers while stopped");
   chk_rdata_hold: assert property (!regReq.rd |=> $stable(regRdata))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (regReq.rd && regReq.addr[1:0] != 2'h0
      |=> regRdata == 32'h0)
      else $error("unmapped offset read nonzero");
endmodule
`default_nettype wire

// [vfd_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module vfd_mem_model (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic memRead,
   input wire logic [31:0] memAddr,
   output logic [31:0] memRdata,
   output logic memRdValid,
   output logic memWait
);
   logic [1:0] stall_q;
   // Random stalls, capped at four cycles so every access completes
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         memWait <= 1'b1;
         stall_q <= 2'h0;
         memRdValid <= 1'b0;
         memRdata <= 32'h0;
      end
      else
      begin
         stall_q <= memWait ? stall_q + 2'h1 : 2'h0;
         memWait <= stall_q != 2'h3 && $urandom_range(0, 1) == 1;
         memRdValid <= memRead && !memWait;
         memRdata <= (memRead && !memWait) ? ~memAddr : ~memRdata;
      end
   end
endmodule
`default_nettype wire

// [test_video_frame_dma.sv]
`timescale 1ns/1ns
`default_nettype none
module test_video_frame_dma;
   localparam int W = 3;
   localparam int H = 2;
   logic ref_clk, rstn, memRead, memWrite, memRdValid, memWait;
   logic snkSop, snkEop, snkValid, snkReady, srcSop, srcEop, srcValid, srcReady;
   logic [31:0] regRdata, memAddr, memWdata, memRdata, base, rd, pend;
   logic [23:0] snkData, srcData;
   logic memRead2, memRdValid2, memWait2, srcSop2, srcEop2, srcValid2, srcReady2;
   logic [31:0] memAddr2, memRdata2;
   logic [23:0] srcData2;
   vfd_pkg::vfd_reg_req_t regIdle;
   logic [23:0] pix[$];
   vfd_pkg::vfd_reg_req_t regReq;
   int mismatches, total_checks, wrCnt, n, srcCnt;
   vfd_video_frame_dma #(.DIRECTION(vfd_pkg::DIR_STREAM_TO_MEM), .MODE(vfd_pkg::MODE_XY),
      .DEFAULT_START(32'h0000_1000), .DEFAULT_PENDING(32'h0000_2000), .WIDTH(W), .HEIGHT(H))
      vfd_video_frame_dma_i (.ref_clk, .rstn, .regReq, .regRdata, .memAddr, .memRead,
      .memWrite, .memWdata, .memRdata, .memRdValid, .memWait, .snkData, .snkSop, .snkEop,
      .snkValid, .snkReady, .srcData, .srcSop, .srcEop, .srcValid, .srcReady);
   vfd_mem_model vfd_mem_model_i (.ref_clk, .rstn, .memRead, .memAddr, .memRdata,
      .memRdValid, .memWait);
   // Second build fetches frames and streams them out, left free of register traffic
   if (1)
   begin : src_build
      vfd_video_frame_dma #(.DIRECTION(vfd_pkg::DIR_MEM_TO_STREAM),
         .MODE(vfd_pkg::MODE_CONSECUTIVE), .DEFAULT_START(32'h0000_3000),
         .DEFAULT_PENDING(32'h0000_3000), .WIDTH(W), .HEIGHT(H))
         vfd_video_frame_dma_i (.ref_clk, .rstn, .regReq(regIdle), .regRdata(),
         .memAddr(memAddr2), .memRead(memRead2), .memWrite(), .memWdata(),
         .memRdata(memRdata2), .memRdValid(memRdValid2), .memWait(memWait2),
         .snkData(24'h0), .snkSop(1'b0), .snkEop(1'b0), .snkValid(1'b0), .snkReady(),
         .srcData(srcData2), .srcSop(srcSop2), .srcEop(srcEop2), .srcValid(srcValid2),
         .srcReady(srcReady2));
      vfd_mem_model vfd_mem_model_i (.ref_clk, .rstn, .memRead(memRead2),
         .memAddr(memAddr2), .memRdata(memRdata2), .memRdValid(memRdValid2),
         .memWait(memWait2));
   end
   // The memory model answers a read with the inverted address
   function automatic logic [23:0] srcExp(input int i);
      return 24'(~(32'h0000_3000 + (32'(i) << 2)));
   endfunction
   always @(posedge ref_clk)
   begin
      #1;
      srcReady2 = $urandom_range(0, 1) == 1;
   end
   always @(posedge ref_clk)
      if (rstn && srcValid2 && srcReady2)
      begin
         check("src data", 32'(srcData2), 32'(srcExp(srcCnt % (W * H))));
         check("src sop", 32'(srcSop2), 32'(srcCnt % (W * H) == 0));
         check("src eop", 32'(srcEop2), 32'(srcCnt % (W * H) == W * H - 1));
         srcCnt++;
      end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic guard;
      if (n >= 50)
      begin
         mismatches++;
         close_out();
      end
   endtask
   // A spare cycle after each access keeps the strobe from being rewritten in one step
   task automatic regAcc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      regReq = '{rd: !wr, wr: wr, addr: a, wdata: d};
      tick();
      regReq = '0;
      rd = regRdata;
      tick();
   endtask
   // Pixel words are four bytes: 24-bit pixels rounded up to a power of two
   function automatic logic [31:0] xyAddr(input logic [31:0] b, input int i);
      return b + ((((i / W) << $clog2(W)) | (i % W)) << 2);
   endfunction
   task automatic sendFrame;
      for (int i = 0; i < W * H; i++)
      begin
         snkData = 24'($urandom);
         snkSop = i == 0;
         snkEop = i == W * H - 1;
         snkValid = 1'b1;
         pix.push_back(snkData);
         for (n = 0; !snkReady && n < 50; n++)
            tick();
         guard();
         tick();
      end
      snkValid = 1'b0;
      for (n = 0; pix.size() != 0 && n < 50; n++)
         tick();
      guard();
      tick();
   endtask
   always @(posedge ref_clk)
      if (rstn && memWrite && !memWait)
      begin
         check("mem addr", memAddr, xyAddr(base, wrCnt % (W * H)));
         check("mem data", memWdata, {8'h0, pix.pop_front()});
         wrCnt++;
      end
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
   initial
   begin
      void'($urandom(32'ha72a));
      {rstn, snkValid, snkSop, snkEop, snkData, regReq, regIdle} = '0;
      srcReady = 1'b1;
      base = 32'h0000_1000;
      repeat (4) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      tick();
      regAcc(1'b0, 4'h0, 32'h0);
      check("active", rd, 32'h0000_1000);
      regAcc(1'b0, 4'h4, 32'h0);
      check("pending", rd, 32'h0000_2000);
      regAcc(1'b0, 4'h8, 32'h0);
      check("dims", rd, {16'(H), 16'(W)});
      regAcc(1'b0, 4'hc, 32'h0);
      check("status", rd & 32'hffff_0fc7, 32'h0102_0784);
      regAcc(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      sendFrame();
      pend = $urandom & 32'hffff_fffc;
      regAcc(1'b1, 4'h4, pend);
      regAcc(1'b0, 4'h4, 32'h0);
      check("pending rw", rd, pend);
      regAcc(1'b1, 4'h0, $urandom);
      regAcc(1'b0, 4'hc, 32'h0);
      check("swap set", rd & 32'h1, 32'h1);
      regAcc(1'b0, 4'h0, 32'h0);
      check("active kept", rd, 32'h0000_1000);
      sendFrame();
      regAcc(1'b0, 4'hc, 32'h0);
      check("swap clear", rd & 32'h1, 32'h0);
      regAcc(1'b0, 4'h0, 32'h0);
      check("active swap", rd, pend);
      regAcc(1'b0, 4'h4, 32'h0);
      check("pending swap", rd, 32'h0000_1000);
      base = pend;
      regAcc(1'b1, 4'hc, 32'h0);
      regAcc(1'b0, 4'hc, 32'h0);
      check("run off", rd & 32'h4, 32'h0);
      repeat (20) tick();
      check("stopped", {30'h0, snkReady, memWrite}, 32'h0);
      regAcc(1'b1, 4'hc, 32'h4);
      sendFrame();
      check("word count", 32'(wrCnt), 32'(3 * W * H));
      check("src beats", 32'(srcCnt >= W * H), 32'h1);
      close_out();
   end
endmodule
bind vfd_video_frame_dma vfd_dma_props #(.WIDTH(WIDTH), .HEIGHT(HEIGHT), .SYM_BITS(SYM_BITS),
   .SYMS(SYMS), .MODE(MODE), .DIRECTION(DIRECTION)) vfd_dma_props_i (.ref_clk, .rstn, .regReq,
   .regRdata, .memAddr,
   .memRead, .memWrite, .memWait, .snkValid, .snkReady, .srcValid);
`default_nettype wire
